// file: sim/panel_power_mode_control_tb.sv
// Self-checking bench for the panel power mode controller
`timescale 1ns/1ns
module panel_power_mode_control_tb;
  import ppmc_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic warning_active = 1'b0;
  logic unacked_fault = 1'b0;
  logic sleep_enable = SLEEP_EN_RESET;
  logic network_option = 1'b0;
  logic power_transfer_option = 1'b0;
  ppmc_panel_t panel;
  ppmc_power_t power;
  ppmc_mode_t mode;
  int error_cnt = 0;
  int samples_checked = 0;

  ////////////////////////////////////////////////////////////////
  // Front panel and controller, short idle count for simulation
  ppmc_panel_model pm (.clock(clock), .panel(panel));
  ppmc_controller #(.TICK_DIVIDE(4), .IDLE_SECONDS(5)) DUT (
    .clock(clock),
    .arst_n(arst_n),
    .panel(panel),
    .warning_active(warning_active),
    .unacked_fault(unacked_fault),
    .sleep_enable(sleep_enable),
    .network_option(network_option),
    .power_transfer_option(power_transfer_option),
    .power(power),
    .mode(mode)
  );

  // Clock of 50 ns period
  initial forever #25 clock = ~clock;

  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Compare one value with its expectation
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask : check

  // Bounded wait for a mode
  task automatic wait_mode(input ppmc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    if (mode !== m)
    begin
      error_cnt++;
      results();
    end
  endtask : wait_mode

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(negedge clock);
    arst_n = 1'b1;
    check(5'(mode), 5'(PPMC_POWER_ON));
    check(power, 5'h1e);
    // Signal and button activity both restart the idle count
    for (int b = 0; b < 4; b += 3)
    begin
      repeat (12) @(negedge clock);
      pm.press(b);
    end
    repeat (12) @(negedge clock);
    check(5'(mode), 5'(PPMC_POWER_ON));
    wait_mode(PPMC_BLANKED);
    check(power, 5'h16);
    repeat (8) @(negedge clock);
    check(5'(mode), 5'(PPMC_BLANKED));
    // Warning holds the panel until acknowledged
    pm.press(3);
    warning_active = 1'b1;
    repeat (40) @(negedge clock);
    warning_active = 1'b0;
    repeat (40) @(negedge clock);
    check(5'(mode), 5'(PPMC_POWER_ON));
    pm.press(5);
    wait_mode(PPMC_BLANKED);
    // Each blocker keeps the panel out of sleep; swapped with no open cycle
    for (int k = 0; k < 4; k++)
    begin
      pm.move((k == 3) ? SEL_MANUAL : SEL_OFF);
      unacked_fault = (k == 0);
      network_option = (k == 1);
      power_transfer_option = (k == 2);
      sleep_enable = 1'b1;
      pm.press(3);
      wait_mode(PPMC_BLANKED);
      repeat (4) @(negedge clock);
      check(5'(mode), 5'(PPMC_BLANKED));
    end
    unacked_fault = 1'b0;
    power_transfer_option = 1'b0;
    pm.move(SEL_OFF);
    // Selector move to off beats sleep entry in the same cycle
    @(negedge clock);
    check(5'(mode), 5'(PPMC_POWER_ON));
    // Sleep, then wake by e-stop, acknowledge, lamp test, selector
    for (int w = 6; w > 2; w--)
    begin
      wait_mode(PPMC_SLEEP);
      check(power, 5'h00);
      if (w == 3)
        pm.move(SEL_MANUAL);
      else
        pm.press(w);
      if (w == 3)
        @(negedge clock);
      check(5'(mode), 5'(PPMC_POWER_ON));
      check(5'(power.menu_only), (w != 6) ? 5'h01 : 5'h00);
    end
    results();
  end
endmodule : panel_power_mode_control_tb

// file: sim/ppmc_panel_model.sv
// Front-panel model: momentary buttons and the mode selector
`timescale 1ns/1ns
module ppmc_panel_model (
  input wire logic clock,
  output ppmc_pkg::ppmc_panel_t panel
);
  import ppmc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Panel rests with no button held and selector at off
  initial panel = '0;

  // Momentary press: high for one cycle, then released
  task automatic press(input int unsigned idx);
    @(negedge clock);
    panel[idx] = 1'b1;
    @(negedge clock);
    panel[idx] = 1'b0;
  endtask : press

  // Selector move, held as a level
  task automatic move(input logic [1:0] pos);
    @(negedge clock);
    panel.selector = pos;
  endtask : move
endmodule : ppmc_panel_model

// file: verilog/ppmc_controller.sv
// Panel power mode controller: idle timer, blanking and sleep
`timescale 1ns/1ns
module ppmc_controller #(
  parameter int unsigned TICK_DIVIDE = ppmc_pkg::TICK_CYCLES,
  parameter int unsigned IDLE_SECONDS = ppmc_pkg::IDLE_MINUTES * ppmc_pkg::SECONDS_PER_MINUTE
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire ppmc_pkg::ppmc_panel_t panel,
  input wire logic warning_active,
  input wire logic unacked_fault,
  input wire logic sleep_enable,
  input wire logic network_option,
  input wire logic power_transfer_option,
  output ppmc_pkg::ppmc_power_t power,
  output ppmc_pkg::ppmc_mode_t mode
);
  import ppmc_pkg::*;

  localparam int unsigned SW = $clog2(IDLE_SECONDS + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input edge detection
  logic [1:0] sel_last;
  logic estop_last;
  logic ack_last;
  logic lamp_last;
  logic other_last;
  logic [1:0] next_sel_last;
  logic activity;
  logic wake_event;
  logic menu_wake;
  logic ack_press;
  logic sel_move;

  // Presses are rising edges; a selector move is any change
  always_comb
  begin
    next_sel_last = panel.selector;
    ack_press = panel.fault_ack & ~ack_last;
    sel_move = panel.selector != sel_last;
    activity = sel_move | ack_press | (panel.estop & ~estop_last)
      | (panel.lamp_test & ~lamp_last) | (panel.other_button & ~other_last)
      | panel.signal_rx;
    wake_event = sel_move | (panel.estop & ~estop_last) | ack_press
      | (panel.lamp_test & ~lamp_last);
    menu_wake = ack_press | (panel.lamp_test & ~lamp_last)
      | (sel_last == SEL_OFF && panel.selector == SEL_MANUAL);
  end

  // Register previous input levels
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_last <= SEL_OFF;
      estop_last <= 1'b0;
      ack_last <= 1'b0;
      lamp_last <= 1'b0;
      other_last <= 1'b0;
    end
    else
    begin
      sel_last <= next_sel_last;
      estop_last <= panel.estop;
      ack_last <= panel.fault_ack;
      lamp_last <= panel.lamp_test;
      other_last <= panel.other_button;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Seconds tick and idle timer
  logic tick;
  logic [SW-1:0] idle_secs;
  logic [SW-1:0] next_idle_secs;
  logic warn_hold;
  logic next_warn_hold;
  logic idle_done;

  ppmc_prescaler #(
    .DIVIDE(TICK_DIVIDE)
  ) u_prescaler (
    .clock(clock),
    .arst_n(arst_n),
    .restart(activity),
    .tick(tick)
  );

  // Idle count, restarted by activity, held at zero by an unacknowledged warning
  always_comb
  begin
    idle_done = idle_secs == SW'(IDLE_SECONDS);
    next_warn_hold = warn_hold;
    // Logic is down while asleep, so a warning is sensed only when awake
    if (warning_active && mode != PPMC_SLEEP)
      next_warn_hold = 1'b1;
    else if (ack_press)
      next_warn_hold = 1'b0;
    next_idle_secs = idle_secs;
    if (activity || next_warn_hold || mode == PPMC_SLEEP)
      next_idle_secs = '0;
    else if (tick && !idle_done)
      next_idle_secs = idle_secs + 1'b1;
  end

  // Register timer state
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idle_secs <= '0;
      warn_hold <= 1'b0;
    end
    else
    begin
      idle_secs <= next_idle_secs;
      warn_hold <= next_warn_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine
  ppmc_mode_t next_mode;
  logic sleep_allowed;
  logic menu_only;
  logic next_menu_only;

  // Choose power-on, blanked or sleep
  always_comb
  begin
    sleep_allowed = sleep_enable && !network_option && !power_transfer_option;
    next_mode = mode;
    next_menu_only = menu_only;
    case (mode)
      PPMC_POWER_ON:
      begin
        // Activity or a fresh warning in the limit cycle keeps the display on
        if (idle_done && !next_warn_hold && !activity)
          next_mode = PPMC_BLANKED;
      end
      PPMC_BLANKED:
      begin
        if (activity || warn_hold)
          next_mode = PPMC_POWER_ON;
        else if (sleep_allowed && !unacked_fault && panel.selector == SEL_OFF
          && !next_warn_hold)
        begin
          next_mode = PPMC_SLEEP;
          next_menu_only = 1'b0;
        end
      end
      PPMC_SLEEP:
      begin
        if (wake_event)
        begin
          next_mode = PPMC_POWER_ON;
          next_menu_only = menu_wake;
        end
        else if (!sleep_allowed)
          next_mode = PPMC_POWER_ON;
      end
      default: next_mode = PPMC_POWER_ON;
    endcase
    // A later selector move while awake ends the menu-only wake
    if (mode != PPMC_SLEEP && sel_move)
      next_menu_only = 1'b0;
  end

  // Register mode
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode <= PPMC_POWER_ON;
      menu_only <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      menu_only <= next_menu_only;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power outputs, decoded from next_mode and registered
  ppmc_power_t next_power;

  always_comb
  begin
    next_power = '0;
    case (next_mode)
      PPMC_POWER_ON:
      begin
        next_power.logic_on = 1'b1;
        next_power.display_on = 1'b1;
        next_power.leds_on = 1'b1;
        next_power.bar_low_on = 1'b1;
      end
      PPMC_BLANKED:
      begin
        next_power.logic_on = 1'b1;
        next_power.leds_on = 1'b1;
        next_power.bar_low_on = 1'b1;
      end
      default: next_power = '0;
    endcase
    next_power.menu_only = next_menu_only;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end
    else
    begin
      power <= next_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sleep_all_off: assert property (@(posedge clock) disable iff (!arst_n)
    mode == PPMC_SLEEP |-> power.display_on == 1'b0 && power.leds_on == 1'b0
      && power.logic_on == 1'b0)
    else $error("sleep with power on");
  a_sleep_needs_enable: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(mode == PPMC_SLEEP) |-> $past(sleep_allowed) && !$past(unacked_fault)
      && $past(panel.selector) == SEL_OFF)
    else $error("sleep entered without conditions");
  a_wake_on_event: assert property (@(posedge clock) disable iff (!arst_n)
    mode == PPMC_SLEEP && wake_event |=> mode == PPMC_POWER_ON && power.display_on)
    else $error("no wake");
  a_activity_restart: assert property (@(posedge clock) disable iff (!arst_n)
    activity |=> idle_secs == '0
      && (mode == PPMC_POWER_ON || $past(mode) == PPMC_SLEEP))
    else $error("timer not restarted");
  a_warning_hold: assert property (@(posedge clock) disable iff (!arst_n)
    warn_hold && !ack_press |=> mode == PPMC_POWER_ON)
    else $error("blanked during warning");
  a_blank_at_limit: assert property (@(posedge clock) disable iff (!arst_n)
    mode == PPMC_POWER_ON && idle_done && !warn_hold && !warning_active && !activity
      |=> mode == PPMC_BLANKED ##0 !power.display_on && power.bar_low_on)
    else $error("display not blanked");
  a_blank_not_early: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(mode == PPMC_BLANKED) |-> $past(idle_done))
    else $error("blanked early");
  a_menu_wake: assert property (@(posedge clock) disable iff (!arst_n)
    mode == PPMC_SLEEP && menu_wake |=> power.menu_only)
    else $error("menu wake flag missing");
endmodule : ppmc_controller

// file: verilog/ppmc_pkg.sv
// Package of constants and types for the panel power mode controller
package ppmc_pkg;
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned IDLE_MINUTES = 10;
  localparam int unsigned SECONDS_PER_MINUTE = 60;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ;
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_MANUAL = 2'h1;
  localparam logic [1:0] SEL_AUTO = 2'h2;
  localparam logic SLEEP_EN_RESET = 1'h0;

  typedef enum logic [1:0] {
    PPMC_POWER_ON,
    PPMC_BLANKED,
    PPMC_SLEEP
  } ppmc_mode_t;

  typedef struct packed {
    logic estop;
    logic fault_ack;
    logic lamp_test;
    logic other_button;
    logic [1:0] selector;
    logic signal_rx;
  } ppmc_panel_t;

  typedef struct packed {
    logic logic_on;
    logic display_on;
    logic leds_on;
    logic bar_low_on;
    logic menu_only;
  } ppmc_power_t;
endpackage : ppmc_pkg

// file: verilog/ppmc_prescaler.sv
// One-cycle tick divider for the idle timer
`timescale 1ns/1ns
module ppmc_prescaler #(
  parameter int unsigned DIVIDE = 20_000_000
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic restart,
  output logic tick
);
  localparam int unsigned W = $clog2(DIVIDE + 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_tick;

  // Count toward the tick, restarting on demand
  always_comb
  begin
    next_tick = 1'b0;
    next_count = count + 1'b1;
    if (restart)
      next_count = '0;
    else if (count == W'(DIVIDE - 1))
    begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  // Register counter and tick
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule : ppmc_prescaler
